// file: rtl/csl_config_strap_latch.sv
// Operation
// R1: once the straps are latched every strap pin drives its alternate-function output value, except the flash speed pin in suspend.
// R2: while reset is held, and until the straps are latched, every strap pin is tri-stated.
// R3: after reset release each strap level is sampled and used as that feature's default.
// R4: the board only biases strap pins with resistors and never drives them.
// R5: a port is disabled only when both its line-disable straps sampled high.
// R6: a line-disable strap sampled low leaves the line enabled, which is the default.
// R7: the flash speed strap selects 30 MHz when low (default) and 60 MHz when high.
// R8: with the flash speed strap latched high the pin floats during suspend.
// R9: with the flash speed strap latched low the pin is driven low during suspend.
// R10: vendor message commands are accepted from reset with no enabling step.
// R11: memory access from the USB side always uses single-ended mode.
// R12: memory access from the register side offers all four read modes.
// R13: configuration writes from the register side are accepted only before attach.
// R14: the init stage after release loads register defaults and latches the straps.
// R15: latched strap values stay fixed until the next reset.
`timescale 1ns/1ns
`include "csl_params.svh"

module csl_config_strap_latch
    import csl_pkg::*;
#(
    parameter int NPORTS = `CSL_NPORTS,
    parameter int SETTLE_CYC = `CSL_SETTLE_CYC
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,

    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,

    // strap pins: neg lines, then pos lines, then flash speed
    input wire logic [2*NPORTS:0] strap_pin_i,
    output logic [2*NPORTS:0] strap_pin_o,
    output logic [2*NPORTS:0] strap_pin_oe_o,
    input wire logic [2*NPORTS:0] strap_alt_i,

    // chip status
    input wire logic suspend_i,
    input wire logic hub_attached_i,
    input wire logic otp_from_usb_i,

    // resulting configuration
    output logic init_done_o,
    output logic [NPORTS-1:0] port_neg_line_disable_o,
    output logic [NPORTS-1:0] port_pos_line_disable_o,
    output logic [NPORTS-1:0] port_disable_o,
    output logic flash_speed_fast_o,
    output logic [6:0] flash_clk_mhz_o,
    output logic vendor_message_commands_en_o,
    output csl_otp_mode_t otp_mode_o,
    output logic smb_config_open_o
);

    // ==========================================================
    // local sizes
    localparam int NSTRAP = 2 * NPORTS + 1;
    localparam int FLASH_IDX = 2 * NPORTS;
    // counter wide enough to reach the settle count
    localparam int CW = $clog2(SETTLE_CYC + 1);

    // ==========================================================
    // parameter checks
    generate
        // the live register holds every strap in one word
        if (NPORTS < 1 || NPORTS > 15)
        begin : g_bad_ports
            $error("NPORTS must lie between 1 and 15");
        end
        if (SETTLE_CYC < 2)
        begin : g_bad_settle
            $error("SETTLE_CYC must cover the two-stage synchroniser");
        end
        if (`CSL_CTRL_OTPM_MSB - `CSL_CTRL_OTPM_LSB != 1)
        begin : g_bad_ctrl_field
            $error("control mode field must be two bits wide");
        end
        if (`CSL_STAT_OTPM_MSB - `CSL_STAT_OTPM_LSB != 1)
        begin : g_bad_stat_field
            $error("status mode field must be two bits wide");
        end
    endgenerate

    // ==========================================================
    // state record
    // one record holds every register of the core
    typedef struct packed {
        csl_state_t st;
        logic [CW-1:0] cnt;
        logic [NSTRAP-1:0] latched;
        logic [NPORTS-1:0] port_dis;
        logic vmsg_en;
        csl_otp_mode_t smb_otp_mode;
        csl_otp_mode_t otp_mode;
        logic ack;
        logic [31:0] rdata;
    } csl_core_state_t;

    localparam csl_core_state_t CSL_RESET_STATE = '{
        st: CSL_ST_HWINIT,
        cnt: '0,
        latched: {NSTRAP{`CSL_STRAP_RST}},
        port_dis: '0,
        vmsg_en: `CSL_CTRL_VMSG_RST,
        smb_otp_mode: CSL_OTP_SINGLE,
        otp_mode: CSL_OTP_SINGLE,
        ack: 1'b0,
        rdata: '0
    };

    csl_core_state_t s_q;
    csl_core_state_t s_d;

    logic req;
    logic init_done;
    logic wr_open;
    logic fast;
    logic [NPORTS-1:0] port_dis_w;
    logic [31:0] rd_word;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;
    logic take;
    logic wr_ctrl;

    csl_strap_if #(.NSTRAP(NSTRAP)) strap ();

    // ==========================================================
    // pad bank with synchroniser
    csl_strap_pad #(
        .NSTRAP(NSTRAP),
        .FLASH_IDX(FLASH_IDX)
    ) u_pad (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .strap(strap.pad),
        .strap_pin_i(strap_pin_i),
        .strap_pin_o(strap_pin_o),
        .strap_pin_oe_o(strap_pin_oe_o),
        .strap_alt_i(strap_alt_i)
    );

    // ==========================================================
    // derived levels
    assign init_done = (s_q.st == CSL_ST_RUN);
    assign fast = s_q.latched[FLASH_IDX];
    // R13: register side closes at attach
    assign wr_open = init_done & ~hub_attached_i;
    assign req = wb_cyc_i & wb_stb_i;
    // a request not yet answered is taken now
    assign take = req & ~s_q.ack;
    // a write lands on the edge where the master sees ack
    assign wr_ctrl = req & s_q.ack & wb_we_i & wb_sel_i[0] & (wb_adr_i == `CSL_ADR_CTRL);

    // holding drive until latch keeps our own drive off the sampled level
    // R1: pins drive only once the straps are held
    assign strap.drive_en = init_done;
    assign strap.flash_fast = fast;
    assign strap.suspend = suspend_i;

    // ==========================================================
    // per-port disable decode
    generate
        for (genvar p = 0; p < NPORTS; p++)
        begin : g_port
            // R5: both lines high disable the port
            // R6: any low line keeps the port on
            assign port_dis_w[p] = strap.sampled[p] & strap.sampled[NPORTS + p];
        end
    endgenerate

    // ==========================================================
    // control word
    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[`CSL_CTRL_VMSG_BIT] = s_q.vmsg_en;
        ctrl_word[`CSL_CTRL_OTPM_MSB:`CSL_CTRL_OTPM_LSB] = s_q.smb_otp_mode;
    end

    // ==========================================================
    // status word
    // status reflects inputs at the request edge
    always_comb
    begin
        status_word = '0;
        status_word[`CSL_STAT_INIT_BIT] = init_done;
        status_word[`CSL_STAT_FAST_BIT] = fast;
        status_word[`CSL_STAT_ATTACH_BIT] = hub_attached_i;
        status_word[`CSL_STAT_SUSP_BIT] = suspend_i;
        status_word[`CSL_STAT_OPEN_BIT] = wr_open;
        status_word[`CSL_STAT_OTPM_MSB:`CSL_STAT_OTPM_LSB] = s_q.otp_mode;
    end

    // ==========================================================
    // read mux
    always_comb
    begin
        rd_word = '0;
        case (wb_adr_i)
            `CSL_ADR_STRAPS:
            begin
                rd_word = 32'(s_q.latched);
            end
            `CSL_ADR_PORTS:
            begin
                rd_word = 32'(s_q.port_dis);
            end
            `CSL_ADR_CTRL:
            begin
                rd_word = ctrl_word;
            end
            `CSL_ADR_STATUS:
            begin
                rd_word = status_word;
            end
            `CSL_ADR_LIVE:
            begin
                // live levels show pin changes after the latch
                rd_word = 32'(strap.sampled);
            end
            default:
            begin
                rd_word = '0;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb
    begin
        s_d = s_q;

        // init sequence
        case (s_q.st)
            CSL_ST_HWINIT:
            begin
                // R14: wait for pins to settle through the synchroniser
                // pins must stay steady until the latch edge
                if (s_q.cnt == CW'(SETTLE_CYC - 1))
                begin
                    s_d.st = CSL_ST_LATCH;
                end
                else
                begin
                    s_d.cnt = CW'(s_q.cnt + 1'b1);
                end
            end
            CSL_ST_LATCH:
            begin
                // R3: capture every strap level once
                s_d.latched = strap.sampled;
                // port decode uses the same synchronised sample
                s_d.port_dis = port_dis_w;
                s_d.st = CSL_ST_RUN;
            end
            CSL_ST_RUN:
            begin
                // R15: latched values left alone here
                s_d.st = CSL_ST_RUN;
            end
            default:
            begin
                s_d.st = CSL_ST_HWINIT;
            end
        endcase

        // bus answer: one cycle after the request, dropped after one
        // so a master holding stb gets a fresh ack every second cycle
        s_d.ack = take;
        if (take)
        begin
            s_d.rdata = rd_word;
        end

        // writes land at the edge where the master sees ack
        if (wr_ctrl)
        begin
            // R13: ignored once attached or before init
            if (wr_open)
            begin
                s_d.vmsg_en = wb_dat_i[`CSL_CTRL_VMSG_BIT];
                // R12: any of the four modes may be chosen
                s_d.smb_otp_mode = csl_otp_mode_t'(wb_dat_i[`CSL_CTRL_OTPM_MSB:`CSL_CTRL_OTPM_LSB]);
            end
        end

        // mode follows the usb flag one cycle later
        // R11: usb side forces single-ended mode
        if (otp_from_usb_i)
        begin
            s_d.otp_mode = CSL_OTP_SINGLE;
        end
        else
        begin
            s_d.otp_mode = s_q.smb_otp_mode;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_i)
    begin
        // synchronous reset: pins float from the first edge of reset
        // R14: reset loads register defaults
        if (!reset_n_i)
        begin
            s_q <= CSL_RESET_STATE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign wb_ack_o = s_q.ack;
    // read data holds until the next bus request, read or write
    assign wb_dat_o = s_q.rdata;
    assign init_done_o = init_done;
    assign port_neg_line_disable_o = s_q.latched[NPORTS-1:0];
    assign port_pos_line_disable_o = s_q.latched[2*NPORTS-1:NPORTS];
    // port disable comes from the latched decode, not the live pins
    assign port_disable_o = s_q.port_dis;
    assign flash_speed_fast_o = fast;
    // R7: speed from the latched strap
    assign flash_clk_mhz_o = fast ? `CSL_FLASH_FAST_MHZ : `CSL_FLASH_SLOW_MHZ;
    // R10: enabled from reset
    assign vendor_message_commands_en_o = s_q.vmsg_en;
    assign otp_mode_o = s_q.otp_mode;
    assign smb_config_open_o = wr_open;

endmodule

// file: rtl/csl_params.svh
`ifndef CSL_PARAMS_SVH
`define CSL_PARAMS_SVH

// ==========================================================
// sizes and timing
`define CSL_NPORTS 4
`define CSL_CLK_PERIOD_NS 40
`define CSL_SETTLE_NS 200
`define CSL_SETTLE_CYC ((`CSL_SETTLE_NS + `CSL_CLK_PERIOD_NS - 1) / `CSL_CLK_PERIOD_NS)

// ==========================================================
// flash clock choices in MHz
`define CSL_FLASH_SLOW_MHZ 7'h1e
`define CSL_FLASH_FAST_MHZ 7'h3c

// ==========================================================
// register byte addresses
`define CSL_ADR_STRAPS 8'h00
`define CSL_ADR_PORTS 8'h04
`define CSL_ADR_CTRL 8'h08
`define CSL_ADR_STATUS 8'h0c
`define CSL_ADR_LIVE 8'h10

// ==========================================================
// control fields and reset values
`define CSL_CTRL_VMSG_BIT 0
`define CSL_CTRL_OTPM_LSB 1
`define CSL_CTRL_OTPM_MSB 2
`define CSL_CTRL_VMSG_RST 1'b1
`define CSL_STRAP_RST 1'b0

// ==========================================================
// status fields
`define CSL_STAT_INIT_BIT 0
`define CSL_STAT_FAST_BIT 1
`define CSL_STAT_ATTACH_BIT 2
`define CSL_STAT_SUSP_BIT 3
`define CSL_STAT_OPEN_BIT 4
`define CSL_STAT_OTPM_LSB 5
`define CSL_STAT_OTPM_MSB 6

`endif

// file: rtl/csl_pkg.sv
package csl_pkg;

    // ==========================================================
    // core sequence states
    typedef enum logic [2:0]
    {
        CSL_ST_HWINIT = 3'h1,
        CSL_ST_LATCH = 3'h2,
        CSL_ST_RUN = 3'h4
    } csl_state_t;

    // ==========================================================
    // one-time-programmable memory read modes
    typedef enum logic [1:0]
    {
        CSL_OTP_SINGLE = 2'h0,
        CSL_OTP_DIFF = 2'h1,
        CSL_OTP_REDUN = 2'h2,
        CSL_OTP_DIFF_REDUN = 2'h3
    } csl_otp_mode_t;

endpackage

// file: rtl/csl_strap_if.sv
`timescale 1ns/1ns

interface csl_strap_if
#(
    parameter int NSTRAP = 9
);
    logic [NSTRAP-1:0] sampled;
    logic drive_en;
    logic flash_fast;
    logic suspend;

    modport core (input sampled, output drive_en, output flash_fast, output suspend);
    modport pad (output sampled, input drive_en, input flash_fast, input suspend);
endinterface

// file: rtl/csl_strap_pad.sv
`timescale 1ns/1ns

module csl_strap_pad
    import csl_pkg::*;
#(
    parameter int NSTRAP = 9,
    parameter int FLASH_IDX = 8
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // core side
    csl_strap_if.pad strap,
    // pins
    input wire logic [NSTRAP-1:0] strap_pin_i,
    output logic [NSTRAP-1:0] strap_pin_o,
    output logic [NSTRAP-1:0] strap_pin_oe_o,
    input wire logic [NSTRAP-1:0] strap_alt_i
);

    typedef struct packed {
        logic [NSTRAP-1:0] sync1;
        logic [NSTRAP-1:0] sync2;
        logic [NSTRAP-1:0] pin_o;
        logic [NSTRAP-1:0] pin_oe;
    } csl_pad_state_t;

    csl_pad_state_t s_q;
    csl_pad_state_t s_d;

    // ==========================================================
    // next state
    always_comb
    begin
        s_d = s_q;
        s_d.sync1 = strap_pin_i;
        s_d.sync2 = s_q.sync1;
        // R2: tri-state until latched
        s_d.pin_oe = {NSTRAP{strap.drive_en}};
        // R1: alternate function outside reset
        s_d.pin_o = strap_alt_i;
        if (strap.drive_en && strap.suspend)
        begin
            // R8: fast strap floats in suspend
            if (strap.flash_fast)
            begin
                s_d.pin_oe[FLASH_IDX] = 1'b0;
            end
            // R9: slow strap driven low in suspend
            else
            begin
                s_d.pin_o[FLASH_IDX] = 1'b0;
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign strap.sampled = s_q.sync2;
    assign strap_pin_o = s_q.pin_o;
    assign strap_pin_oe_o = s_q.pin_oe;

endmodule

// file: dv/csl_sl_assertions.sv
`timescale 1ns/1ns
`include "csl_params.svh"
module csl_sl_assertions
    import csl_pkg::*;
#(
    parameter int NPORTS = 4
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // pins and chip status
    input wire logic [2*NPORTS:0] strap_pin_i,
    input wire logic [2*NPORTS:0] strap_pin_o,
    input wire logic [2*NPORTS:0] strap_pin_oe_o,
    input wire logic [2*NPORTS:0] strap_alt_i,
    input wire logic suspend_i,
    input wire logic hub_attached_i,
    input wire logic otp_from_usb_i,
    // configuration
    input wire logic init_done_o,
    input wire logic [NPORTS-1:0] port_neg_line_disable_o,
    input wire logic [NPORTS-1:0] port_pos_line_disable_o,
    input wire logic [NPORTS-1:0] port_disable_o,
    input wire logic flash_speed_fast_o,
    input wire logic [6:0] flash_clk_mhz_o,
    input wire logic vendor_message_commands_en_o,
    input wire csl_otp_mode_t otp_mode_o,
    input wire logic smb_config_open_o
);
    localparam int F = 2*NPORTS;
    wire [F:0] latched = {flash_speed_fast_o, port_pos_line_disable_o, port_neg_line_disable_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // ==========================================
    // properties
    sequence s_latch;
        $rose(init_done_o);
    endsequence
    sequence s_run;
        init_done_o && $past(init_done_o);
    endsequence
    property p_tri;
        !init_done_o |-> strap_pin_oe_o == '0;
    endproperty
    property p_alt;
        s_run |-> strap_pin_oe_o[F-1:0] == '1 && strap_pin_o[F-1:0] == $past(strap_alt_i[F-1:0]);
    endproperty
    property p_latch;
        s_latch |-> latched == $past(strap_pin_i, 2);
    endproperty
    property p_hold;
        s_run |-> $stable(latched);
    endproperty
    property p_port;
        port_disable_o == (port_neg_line_disable_o & port_pos_line_disable_o);
    endproperty
    property p_dflt;
        !init_done_o |-> port_disable_o == '0 && latched == '0;
    endproperty
    property p_speed;
        flash_clk_mhz_o == (flash_speed_fast_o ? `CSL_FLASH_FAST_MHZ : `CSL_FLASH_SLOW_MHZ);
    endproperty
    property p_sfast;
        s_run ##0 (suspend_i && flash_speed_fast_o) |=> !strap_pin_oe_o[F];
    endproperty
    property p_sslow;
        s_run ##0 (suspend_i && !flash_speed_fast_o) |=> strap_pin_oe_o[F] && !strap_pin_o[F];
    endproperty
    property p_vmsg;
        s_latch |-> vendor_message_commands_en_o && otp_mode_o == CSL_OTP_SINGLE;
    endproperty
    property p_usb;
        otp_from_usb_i |=> otp_mode_o == CSL_OTP_SINGLE;
    endproperty
    property p_open;
        smb_config_open_o == (init_done_o && !hub_attached_i);
    endproperty
    a_tri: assert property (p_tri) else $error("strap pin driven before latch");
    a_alt: assert property (p_alt) else $error("alternate output wrong");
    a_latch: assert property (p_latch) else $error("latched value wrong");
    a_hold: assert property (p_hold) else $error("latched value moved");
    a_port: assert property (p_port) else $error("port disable wrong");
    a_dflt: assert property (p_dflt) else $error("default not enabled");
    a_speed: assert property (p_speed) else $error("flash clock wrong");
    a_sfast: assert property (p_sfast) else $error("fast pin not floated");
    a_sslow: assert property (p_sslow) else $error("slow pin not low");
    a_vmsg: assert property (p_vmsg) else $error("init defaults wrong");
    a_usb: assert property (p_usb) else $error("usb mode not single");
    a_open: assert property (p_open) else $error("config window wrong");
endmodule

bind csl_config_strap_latch csl_sl_assertions #(.NPORTS(NPORTS)) csl_sl_assertions_i (.*);

// file: dv/csl_board_model.sv
`timescale 1ns/1ns
module csl_board_model
#(
    parameter int NSTRAP = 9
)
(
    // board resistor levels and device drive
    input wire logic [NSTRAP-1:0] pull_i,
    input wire logic [NSTRAP-1:0] pin_drv_i,
    input wire logic [NSTRAP-1:0] pin_oe_i,
    // resolved pin level
    output logic [NSTRAP-1:0] pin_level_o
);
    assign pin_level_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & pull_i);
endmodule

// file: dv/test_csl_config_strap_latch.sv
`timescale 1ns/1ns
module test_csl_config_strap_latch
    import csl_pkg::*;
;
    localparam int NP = 4;
    localparam int F = 2*NP;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [3:0] sel_next = 4'hf;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [F:0] alt = 9'h000;
    logic [F:0] pull = 9'h000;
    logic [F:0] pin_lvl, pin_o, pin_oe;
    logic suspend_i = 1'b0;
    logic hub_attached_i = 1'b0;
    logic otp_from_usb_i = 1'b0;
    logic init_done_o, fast_o, vmsg_o, open_o;
    logic [NP-1:0] neg_o, pos_o, dis_o;
    logic [6:0] mhz_o;
    csl_otp_mode_t otp_o;
    logic [31:0] q;
    logic [F:0] pats [4] = '{9'h000, 9'h1ff, 9'h136, 9'h0c9};
    int err_total = 0;
    int n_checks = 0;

    always #20 clk_i = ~clk_i;

    csl_config_strap_latch #(.NPORTS(NP)) csl_config_strap_latch_i
    (
        .clk_i(clk_i), .reset_n_i(reset_n_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .strap_pin_i(pin_lvl), .strap_pin_o(pin_o), .strap_pin_oe_o(pin_oe),
        .strap_alt_i(alt), .suspend_i(suspend_i), .hub_attached_i(hub_attached_i),
        .otp_from_usb_i(otp_from_usb_i), .init_done_o(init_done_o),
        .port_neg_line_disable_o(neg_o), .port_pos_line_disable_o(pos_o),
        .port_disable_o(dis_o), .flash_speed_fast_o(fast_o), .flash_clk_mhz_o(mhz_o),
        .vendor_message_commands_en_o(vmsg_o), .otp_mode_o(otp_o),
        .smb_config_open_o(open_o)
    );

    csl_board_model #(.NSTRAP(F+1)) csl_board_model_i
    (
        .pull_i(pull), .pin_drv_i(pin_o), .pin_oe_i(pin_oe), .pin_level_o(pin_lvl)
    );

    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel_next;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        chk(wb_ack_o, 1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic boot(input logic [F:0] p);
        int n;
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        pull <= p;
        repeat (20) @(posedge clk_i);
        chk(pin_oe, 0);
        reset_n_i <= 1'b1;
        wb(1'b1, 8'h08, 32'h0);
        n = 0;
        while (init_done_o !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(init_done_o, 1);
        chk({fast_o, pos_o, neg_o}, p);
        chk(dis_o, p[3:0] & p[7:4]);
        chk(mhz_o, p[F] ? 7'h3c : 7'h1e);
        chk(vmsg_o, 1);
        wb(1'b0, 8'h00, 32'h0);
        chk(q, p);
        wb(1'b0, 8'h04, 32'h0);
        chk(q, p[3:0] & p[7:4]);
        wb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h1);
    endtask

    task automatic run_chk(input logic [F:0] p);
        alt <= ~p;
        pull <= ~p;
        repeat (4) @(posedge clk_i);
        chk(pin_oe, 9'h1ff);
        chk(pin_o[7:0], 8'(~p[7:0]));
        chk({fast_o, pos_o, neg_o}, p);
        wb(1'b0, 8'h10, 32'h0);
        chk(q[7:0], 8'(~p[7:0]));
        suspend_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(pin_oe[F], !p[F]);
        if (!p[F])
            chk(pin_o[F], 0);
        chk(pin_oe[F-1:0], 8'hff);
        wb(1'b0, 8'h0c, 32'h0);
        chk(q, {25'h0, 2'h0, 1'b1, 1'b1, 1'b0, p[F], 1'b1});
        suspend_i <= 1'b0;
    endtask

    task automatic regs;
        chk(open_o, 1);
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, 8'h08, {29'h0, i[1:0], 1'b0});
            wb(1'b0, 8'h08, 32'h0);
            chk(q, {29'h0, i[1:0], 1'b0});
            chk(otp_o, i);
        end
        sel_next = 4'he;
        wb(1'b1, 8'h08, 32'h1);
        sel_next = 4'hf;
        wb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h6);
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b0, 8'h00, 32'h0);
        chk(q, pats[3]);
        otp_from_usb_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(otp_o, 0);
        otp_from_usb_i <= 1'b0;
        hub_attached_i <= 1'b1;
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h6);
        chk(open_o, 0);
        wb(1'b0, 8'h14, 32'h0);
        chk(q, 32'h0);
        hub_attached_i <= 1'b0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        foreach (pats[k])
        begin
            boot(pats[k]);
            run_chk(pats[k]);
            $display("strap pattern %h done", pats[k]);
        end
        regs();
        $display("register access done");
        report_and_stop();
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        report_and_stop();
    end
endmodule
